// ===== common/epiu_pkg.sv
// Purpose: Shared constants for the external pin interrupt unit
// Assumes: 32-bit classic Wishbone, register index times four gives the byte address
// Notes:   Reset values of all software registers are zero
package epiu_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_PINS     = 18;
	localparam int unsigned MAX_PINS     = 24;
	localparam int unsigned SYNC_CYCLES  = 3;
	localparam int unsigned CFG_FIELD_W  = 4;
	localparam int unsigned PINS_PER_CFG = 8;
	localparam int unsigned IDX_W        = 6;

	// ----------------------------------------------------------------
	// Register indices (byte address is index times four)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_MODULE_CONTROL   = 6'h00;
	localparam logic [5:0] IDX_SYNC_STATUS      = 6'h01;
	localparam logic [5:0] IDX_NMI_SETUP        = 6'h02;
	localparam logic [5:0] IDX_NMI_FLAG         = 6'h03;
	localparam logic [5:0] IDX_EVENT_OUT_EN     = 6'h04;
	localparam logic [5:0] IDX_IRQ_ENABLE_CLEAR = 6'h08;
	localparam logic [5:0] IDX_IRQ_ENABLE_SET   = 6'h0c;
	localparam logic [5:0] IDX_PIN_IRQ_FLAGS    = 6'h10;
	localparam logic [5:0] IDX_SLEEP_EXIT_EN    = 6'h14;
	localparam logic [5:0] IDX_SENSE_SETUP_0    = 6'h18;
	localparam logic [5:0] IDX_SENSE_SETUP_1    = 6'h1c;
	localparam logic [5:0] IDX_SENSE_SETUP_2    = 6'h20;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SOFT_RESET_BIT  = 0;
	localparam int unsigned ENABLE_BIT      = 1;
	localparam int unsigned SYNC_BUSY_BIT   = 7;
	localparam int unsigned NMI_FILTER_BIT  = 3;
	localparam int unsigned NMI_FLAG_BIT    = 0;
	localparam int unsigned FILTER_EN_BIT   = 3;
	localparam logic [31:0] REG_RESET       = 32'h0000_0000;
	localparam logic [3:0]  NMI_SETUP_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Sense codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SENSE_NONE = 3'h0;
	localparam logic [2:0] SENSE_RISE = 3'h1;
	localparam logic [2:0] SENSE_FALL = 3'h2;
	localparam logic [2:0] SENSE_BOTH = 3'h3;
	localparam logic [2:0] SENSE_HIGH = 3'h4;
	localparam logic [2:0] SENSE_LOW  = 3'h5;

	typedef enum logic [0:0] {
		SYNC_IDLE = 1'b0,
		SYNC_BUSY = 1'b1
	} epiu_sync_e;

endpackage : epiu_pkg

// ===== core/epiu_core.sv
// Purpose: External pin interrupt unit with flags, requests, events and wake-up
// Assumes: Pins are asynchronous; detection and filtering run on clk_i
// Notes:   Control writes pass a modelled crossing of SYNC_CYCLES clocks
`timescale 1ns/1ps

// Functional notes
// - One flag per pin plus nonmaskable flag
// - Detection sets pin flag or nonmaskable flag
// - Enable-set writes enable, enable-clear disables
// - Nonmaskable flag always requests, no enable
// - Request when flag set and enabled
// - Request holds until clear, disable, reset
// - One request output per pin plus nonmaskable
// - Shared line: first programmed pin wins
// - Event enable bits 0 to 17
// - Matching pin emits event when enabled
// - Wake bit allows or blocks pin wake-up
// - Wake needs match, irq enable, wake bit
// - Sync busy sets at once, clears when done
// - Control write while busy stalls bus
// - Soft reset and enable writes are synchronized
// - Sense codes: none, rise, fall, both, high, low
// - Level mode re-sets cleared flag while matching
// - Filter takes majority of three samples
// - Soft reset wins, resets all, disables
module epiu_core #(
	parameter int unsigned N_PINS      = epiu_pkg::NUM_PINS,
	parameter int unsigned SYNC_CYCLES = epiu_pkg::SYNC_CYCLES
) (
	input  wire logic              clk_i,      // 250 MHz clock
	input  wire logic              rst_i,      // Synchronous reset, high
	input  wire logic [7:0]        adr_i,      // Byte address
	input  wire logic [31:0]       dat_i,      // Write data
	output logic      [31:0]       dat_o,      // Read data
	input  wire logic              we_i,       // Write enable
	input  wire logic [3:0]        sel_i,      // Byte selects
	input  wire logic              cyc_i,      // Cycle
	input  wire logic              stb_i,      // Strobe
	output logic                   ack_o,      // Acknowledge
	input  wire logic [N_PINS-1:0] pin_a_i,    // First candidate pin per line
	input  wire logic [N_PINS-1:0] pin_b_i,    // Second candidate pin per line
	input  wire logic [N_PINS-1:0] route_a_i,  // First pin routed to line
	input  wire logic [N_PINS-1:0] route_b_i,  // Second pin routed to line
	input  wire logic              nmi_pin_i,  // Nonmaskable pin
	output logic      [N_PINS-1:0] irq_o,      // Per-pin interrupt request
	output logic                   nmi_irq_o,  // Nonmaskable request
	output logic      [N_PINS-1:0] event_o,    // Per-pin event
	output logic                   wake_o      // Wake-up request
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (N_PINS < 1 || N_PINS > epiu_pkg::MAX_PINS) begin : g_bad_pins
		$error("N_PINS must lie between 1 and 24");
	end
	if (SYNC_CYCLES < 1 || SYNC_CYCLES > 255) begin : g_bad_sync
		$error("SYNC_CYCLES must lie between 1 and 255");
	end

	localparam int unsigned NP = N_PINS + 1;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [N_PINS-1:0]     irq_en;
	logic [N_PINS-1:0]     evt_en;
	logic [N_PINS-1:0]     wake_en;
	logic [N_PINS-1:0]     flags;
	logic                  nmi_flag;
	logic [3:0]            nmi_setup;
	logic [31:0]           sense_setup [3];
	logic                  ctl_enable;
	logic                  ctl_soft_reset;
	logic                  run_enable;
	epiu_pkg::epiu_sync_e  sync_state;
	logic [7:0]            sync_cnt;
	logic                  soft_done;
	logic                  wipe;
	logic [N_PINS-1:0]     a_meta, a_sync, b_meta, b_sync;
	logic                  nmi_meta, nmi_sync;
	logic [N_PINS-1:0]     owner_b;
	logic [NP-1:0]         raw;
	logic [NP-1:0]         smp1, smp2;
	logic [NP-1:0]         cur;
	logic [NP-1:0]         prv;
	logic [NP-1:0]         match;
	logic                  ack;
	logic [31:0]           rdata;
	logic [31:0]           bmask;
	logic [31:0]           wbits;
	logic [5:0]            idx;
	logic                  req, ctrl_wr, stall, take, wr;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_meta   <= '0;
			a_sync   <= '0;
			b_meta   <= '0;
			b_sync   <= '0;
			nmi_meta <= 1'b0;
			nmi_sync <= 1'b0;
		end else begin
			a_meta   <= pin_a_i;
			a_sync   <= a_meta;
			b_meta   <= pin_b_i;
			b_sync   <= b_meta;
			nmi_meta <= nmi_pin_i;
			nmi_sync <= nmi_meta;
		end
	end

	// ----------------------------------------------------------------
	// Line ownership: a pin keeps the line until its route drops
	// ----------------------------------------------------------------
	genvar gi;
	for (gi = 0; gi < N_PINS; gi++) begin : g_route
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				owner_b[gi] <= 1'b0;
			end else if (route_b_i[gi] && !route_a_i[gi]) begin
				owner_b[gi] <= 1'b1;
			end else if (route_a_i[gi] && !route_b_i[gi]) begin
				owner_b[gi] <= 1'b0;
			end
		end
		assign raw[gi] = owner_b[gi] ? (b_sync[gi] & route_b_i[gi])
		                             : (a_sync[gi] & route_a_i[gi]);
	end
	assign raw[N_PINS] = nmi_sync;

	// ----------------------------------------------------------------
	// Filter and sense detection, one slice per source
	// ----------------------------------------------------------------
	for (gi = 0; gi < NP; gi++) begin : g_detect
		logic [2:0] code;
		logic       filt_on;
		logic       voted;
		if (gi == N_PINS) begin : g_nmi
			assign code    = nmi_setup[2:0];
			assign filt_on = nmi_setup[epiu_pkg::NMI_FILTER_BIT];
		end else begin : g_ext
			assign code    = sense_setup[gi / epiu_pkg::PINS_PER_CFG]
			                 [(gi % epiu_pkg::PINS_PER_CFG) * epiu_pkg::CFG_FIELD_W +: 3];
			assign filt_on = sense_setup[gi / epiu_pkg::PINS_PER_CFG]
			                 [(gi % epiu_pkg::PINS_PER_CFG) * epiu_pkg::CFG_FIELD_W
			                  + epiu_pkg::FILTER_EN_BIT];
		end
		// Majority of three samples keeps single-cycle glitches out
		assign voted   = (raw[gi] & smp1[gi]) | (raw[gi] & smp2[gi])
		                 | (smp1[gi] & smp2[gi]);
		assign cur[gi] = filt_on ? voted : raw[gi];

		always_ff @(posedge clk_i) begin
			if (wipe) begin
				smp1[gi] <= 1'b0;
				smp2[gi] <= 1'b0;
				prv[gi]  <= 1'b0;
			end else begin
				smp1[gi] <= raw[gi];
				smp2[gi] <= smp1[gi];
				prv[gi]  <= cur[gi];
			end
		end

		always_comb begin
			case (code)
				epiu_pkg::SENSE_NONE: match[gi] = 1'b0;
				epiu_pkg::SENSE_RISE: match[gi] = cur[gi] & ~prv[gi];
				epiu_pkg::SENSE_FALL: match[gi] = ~cur[gi] & prv[gi];
				epiu_pkg::SENSE_BOTH: match[gi] = cur[gi] ^ prv[gi];
				epiu_pkg::SENSE_HIGH: match[gi] = cur[gi];
				epiu_pkg::SENSE_LOW:  match[gi] = ~cur[gi];
				default:              match[gi] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign idx     = adr_i[7:2];
	assign bmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wbits   = dat_i & bmask;
	assign req     = cyc_i & stb_i & ~ack;
	assign ctrl_wr = req & we_i & sel_i[0] & (idx == epiu_pkg::IDX_MODULE_CONTROL);
	// A control write meeting a busy crossing waits without an ack
	assign stall   = ctrl_wr & (sync_state == epiu_pkg::SYNC_BUSY);
	assign take    = req & ~stall;
	assign wr      = take & we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= take;
		end
	end
	assign ack_o = ack;

	// ----------------------------------------------------------------
	// Control crossing
	// ----------------------------------------------------------------
	assign soft_done = (sync_state == epiu_pkg::SYNC_BUSY) && ctl_soft_reset
	                   && (sync_cnt == 8'(SYNC_CYCLES - 1));
	assign wipe      = rst_i | soft_done;

	always_ff @(posedge clk_i) begin
		if (wipe) begin
			sync_state     <= epiu_pkg::SYNC_IDLE;
			sync_cnt       <= 8'h00;
			ctl_enable     <= 1'b0;
			ctl_soft_reset <= 1'b0;
			run_enable     <= 1'b0;
		end else begin
			case (sync_state)
				epiu_pkg::SYNC_IDLE: begin
					if (wr && sel_i[0] && idx == epiu_pkg::IDX_MODULE_CONTROL) begin
						sync_state <= epiu_pkg::SYNC_BUSY;
						sync_cnt   <= 8'h00;
						if (dat_i[epiu_pkg::SOFT_RESET_BIT]) begin
							ctl_soft_reset <= 1'b1;
						end else begin
							ctl_enable <= dat_i[epiu_pkg::ENABLE_BIT];
						end
					end
				end
				epiu_pkg::SYNC_BUSY: begin
					if (sync_cnt == 8'(SYNC_CYCLES - 1)) begin
						sync_state <= epiu_pkg::SYNC_IDLE;
						run_enable <= ctl_enable;
					end else begin
						sync_cnt <= sync_cnt + 8'h01;
					end
				end
				default: begin
					sync_state <= epiu_pkg::SYNC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (wipe) begin
			nmi_setup <= epiu_pkg::NMI_SETUP_RESET;
			evt_en    <= '0;
			wake_en   <= '0;
			for (int k = 0; k < 3; k++) begin
				sense_setup[k] <= epiu_pkg::REG_RESET;
			end
		end else if (wr) begin
			case (idx)
				epiu_pkg::IDX_NMI_SETUP: begin
					if (sel_i[0]) begin
						nmi_setup <= dat_i[3:0];
					end
				end
				epiu_pkg::IDX_EVENT_OUT_EN: begin
					evt_en <= (evt_en & ~bmask[N_PINS-1:0]) | wbits[N_PINS-1:0];
				end
				epiu_pkg::IDX_SLEEP_EXIT_EN: begin
					wake_en <= (wake_en & ~bmask[N_PINS-1:0]) | wbits[N_PINS-1:0];
				end
				epiu_pkg::IDX_SENSE_SETUP_0: begin
					sense_setup[0] <= (sense_setup[0] & ~bmask) | wbits;
				end
				epiu_pkg::IDX_SENSE_SETUP_1: begin
					sense_setup[1] <= (sense_setup[1] & ~bmask) | wbits;
				end
				epiu_pkg::IDX_SENSE_SETUP_2: begin
					sense_setup[2] <= (sense_setup[2] & ~bmask) | wbits;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt enable mask
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (wipe) begin
			irq_en <= '0;
		end else if (wr && idx == epiu_pkg::IDX_IRQ_ENABLE_SET) begin
			irq_en <= irq_en | wbits[N_PINS-1:0];
		end else if (wr && idx == epiu_pkg::IDX_IRQ_ENABLE_CLEAR) begin
			irq_en <= irq_en & ~wbits[N_PINS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Flags: a detection in the clearing cycle keeps the flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (wipe) begin
			flags    <= '0;
			nmi_flag <= 1'b0;
		end else begin
			flags <= (flags & ~((wr && idx == epiu_pkg::IDX_PIN_IRQ_FLAGS)
			                    ? wbits[N_PINS-1:0] : '0))
			         | (match[N_PINS-1:0] & {N_PINS{run_enable}});
			// Nonmaskable detection does not depend on the module enable
			nmi_flag <= (nmi_flag & ~(wr && idx == epiu_pkg::IDX_NMI_FLAG
			                          && wbits[epiu_pkg::NMI_FLAG_BIT]))
			            | match[N_PINS];
		end
	end

	// ----------------------------------------------------------------
	// Requests, events and wake-up
	// ----------------------------------------------------------------
	assign irq_o     = flags & irq_en;
	assign nmi_irq_o = nmi_flag;

	always_ff @(posedge clk_i) begin
		if (wipe) begin
			event_o <= '0;
			wake_o  <= 1'b0;
		end else begin
			event_o <= match[N_PINS-1:0] & evt_en & {N_PINS{run_enable}};
			wake_o  <= |(match[N_PINS-1:0] & irq_en & wake_en)
			           & run_enable;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			epiu_pkg::IDX_MODULE_CONTROL: begin
				rdata[epiu_pkg::SOFT_RESET_BIT] = ctl_soft_reset;
				rdata[epiu_pkg::ENABLE_BIT]     = ctl_enable;
			end
			epiu_pkg::IDX_SYNC_STATUS: begin
				rdata[epiu_pkg::SYNC_BUSY_BIT] = (sync_state == epiu_pkg::SYNC_BUSY);
			end
			epiu_pkg::IDX_NMI_SETUP: begin
				rdata[3:0] = nmi_setup;
			end
			epiu_pkg::IDX_NMI_FLAG: begin
				rdata[epiu_pkg::NMI_FLAG_BIT] = nmi_flag;
			end
			epiu_pkg::IDX_EVENT_OUT_EN: begin
				rdata[N_PINS-1:0] = evt_en;
			end
			epiu_pkg::IDX_IRQ_ENABLE_CLEAR,
			epiu_pkg::IDX_IRQ_ENABLE_SET: begin
				rdata[N_PINS-1:0] = irq_en;
			end
			epiu_pkg::IDX_PIN_IRQ_FLAGS: begin
				rdata[N_PINS-1:0] = flags;
			end
			epiu_pkg::IDX_SLEEP_EXIT_EN: begin
				rdata[N_PINS-1:0] = wake_en;
			end
			epiu_pkg::IDX_SENSE_SETUP_0: begin
				rdata = sense_setup[0];
			end
			epiu_pkg::IDX_SENSE_SETUP_1: begin
				rdata = sense_setup[1];
			end
			epiu_pkg::IDX_SENSE_SETUP_2: begin
				rdata = sense_setup[2];
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (take) begin
			dat_o <= rdata;
		end
	end

endmodule : epiu_core

// ===== dv/epiu_core_props.sv
// Purpose: Port-level checks for epiu_core
// Assumes: Control writes are word index 0 with byte lane 0 selected
// Notes:   Busy timing is tracked from control-write acknowledges
`timescale 1ns/1ps
module epiu_core_props #(
	parameter int unsigned N_PINS      = epiu_pkg::NUM_PINS,
	parameter int unsigned SYNC_CYCLES = epiu_pkg::SYNC_CYCLES
) (
	input wire logic              clk_i,     // Clock
	input wire logic              rst_i,     // Reset
	input wire logic [7:0]        adr_i,     // Byte address
	input wire logic [31:0]       dat_i,     // Write data
	input wire logic [31:0]       dat_o,     // Read data
	input wire logic              we_i,      // Write enable
	input wire logic [3:0]        sel_i,     // Byte selects
	input wire logic              cyc_i,     // Cycle
	input wire logic              stb_i,     // Strobe
	input wire logic              ack_o,     // Acknowledge
	input wire logic [N_PINS-1:0] irq_o,     // Pin requests
	input wire logic              nmi_irq_o, // Nonmaskable request
	input wire logic [N_PINS-1:0] event_o,   // Events
	input wire logic              wake_o     // Wake-up
);
	localparam int GAP    = SYNC_CYCLES + 1;
	localparam int SR_LIM = SYNC_CYCLES + 3;
	logic [7:0] since_ctrl;
	logic       ctrl_ack;
	logic       rd_status;
	assign ctrl_ack  = ack_o && we_i && (adr_i[7:2] == 6'h00) && sel_i[0];
	assign rd_status = ack_o && !we_i && (adr_i == 8'h04);
	// ----------------------------------------------------------------
	// Helper
	// ----------------------------------------------------------------
	// Saturates so a long-idle bus never looks like a fresh control write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			since_ctrl <= 8'hff;
		else if (ctrl_ack)
			since_ctrl <= 8'h01;
		else if (since_ctrl != 8'hff)
			since_ctrl <= since_ctrl + 8'h01;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
		(irq_o == '0) && !nmi_irq_o && (event_o == '0) && !wake_o)
		else $error("outputs active after reset");
	ack_latency_a: assert property ((cyc_i && stb_i && !ack_o && !(we_i &&
		(adr_i[7:2] == 6'h00))) |=> ack_o) else $error("late acknowledge");
	stall_gap_a: assert property (ctrl_ack |-> since_ctrl >= GAP)
		else $error("control write not stalled");
	busy_seen_a: assert property (rd_status && since_ctrl <= SYNC_CYCLES |-> dat_o[7])
		else $error("busy missing");
	busy_done_a: assert property (rd_status && since_ctrl >= GAP + 1 |-> !dat_o[7])
		else $error("busy stuck");
	irq_off_a: assert property (ack_o && we_i && adr_i == 8'h20 && sel_i == 4'hf |->
		(irq_o & dat_i[N_PINS-1:0]) == '0) else $error("request after disable");
	event_gate_a: assert property (ack_o && we_i && adr_i == 8'h10 && sel_i == 4'hf |=>
		(event_o & ~$past(dat_i[N_PINS-1:0])) == '0) else $error("disabled event");
	soft_reset_a: assert property (ctrl_ack && dat_i[0] |-> ##[1:SR_LIM]
		((irq_o == '0) && (event_o == '0) && !wake_o)) else $error("soft reset no effect");
	stall_c: cover property (ctrl_ack && since_ctrl == GAP);
	nmi_c: cover property ($rose(nmi_irq_o));
	event_c: cover property (event_o != '0);
endmodule : epiu_core_props

bind epiu_core epiu_core_props #(.N_PINS(N_PINS), .SYNC_CYCLES(SYNC_CYCLES)) epiu_core_props_inst (
	.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
	.irq_o, .nmi_irq_o, .event_o, .wake_o);

// ===== dv/epiu_far_model.sv
// Purpose: Event system and nonmaskable line receiver beside the core
// Assumes: Events are taken every cycle they stand high
// Notes:   Counter saturates instead of wrapping, so a long burst never reads as none
`timescale 1ns/1ps
module epiu_far_model #(
	parameter int unsigned N_PINS = epiu_pkg::NUM_PINS
) (
	input  wire logic              clk_i,       // Clock
	input  wire logic              rst_i,       // Reset
	input  wire logic [N_PINS-1:0] event_i,     // Events from the core
	input  wire logic              nmi_irq_i,   // Nonmaskable request
	output logic      [15:0]       event_cnt_o, // Cycles with any event
	output logic                   nmi_seen_o   // Nonmaskable request taken
);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			event_cnt_o <= 16'h0000;
		else if (event_i != '0 && event_cnt_o != 16'hffff)
			event_cnt_o <= event_cnt_o + 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			nmi_seen_o <= 1'b0;
		else if (nmi_irq_i)
			nmi_seen_o <= 1'b1;
	end
endmodule : epiu_far_model

// ===== dv/tb.sv
// Purpose: Register-level test of epiu_core
// Assumes: Default sync length; pins change on rising edges
// Notes:   Absence checks wait a fixed span that covers sync and filter
`timescale 1ns/1ps
module tb;
	localparam int NP = epiu_pkg::NUM_PINS;
	localparam logic [7:0] MAP [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20,
		8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80};
	logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, nmi_pin_i, nmi_irq_o, wake_o, nmi_seen;
	logic [7:0]    adr_i;
	logic [31:0]   dat_i, dat_o, q;
	logic [3:0]    sel_i;
	logic [NP-1:0] pin_a_i, pin_b_i, route_a_i, route_b_i, irq_o, event_o;
	logic [15:0]   event_cnt;
	int            n_errors, checks, lat;

	epiu_core epiu_core_inst (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
		.stb_i, .ack_o, .pin_a_i, .pin_b_i, .route_a_i, .route_b_i, .nmi_pin_i, .irq_o,
		.nmi_irq_o, .event_o, .wake_o);
	epiu_far_model epiu_far_model_inst (.clk_i, .rst_i, .event_i(event_o),
		.nmi_irq_i(nmi_irq_o), .event_cnt_o(event_cnt), .nmi_seen_o(nmi_seen));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		// Ack and read data are taken on the rising edge that also releases the request
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk_i);
		end
		if (n >= 50) begin
			n_errors++;
			end_sim();
		end else begin
			q = dat_o;
			lat = n;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	function automatic logic sig(input int k);
		if (k < NP)
			return irq_o[k];
		if (k == NP)
			return nmi_irq_o;
		if (k == NP + 1)
			return wake_o;
		return nmi_seen && (event_cnt != 16'h0000);
	endfunction : sig
	task automatic wait_sig(input int k, input logic v);
		int n;
		n = 0;
		while (sig(k) !== v && n < 40) begin
			n++;
			@(posedge clk_i);
		end
		checks++;
		if (sig(k) !== v) begin
			$display("wrong value line %0d exp %b got %b", k, v, sig(k));
			n_errors++;
			end_sim();
		end
	endtask : wait_sig

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, nmi_pin_i, adr_i, dat_i, sel_i} = '0;
		rst_i = 1'b1;
		{pin_a_i, pin_b_i, route_b_i} = '0;
		route_a_i = '1;
		n_errors = 0;
		checks = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (MAP[i]) rd(MAP[i], epiu_pkg::REG_RESET);
		wr_go: begin
			wb(1'b1, 8'h00, 32'h2);
			rd(8'h04, 32'h80);
			rd(8'h00, 32'h2);
			rd(8'h04, 32'h0);
		end
		wb(1'b1, 8'h60, 32'h0000_4b41);
		wb(1'b1, 8'h30, 32'h0000_000f);
		wb(1'b1, 8'h30, 32'h0);
		rd(8'h20, 32'hf);
		pin_a_i[0] <= 1'b1;
		wait_sig(0, 1'b1);
		rd(8'h40, 32'h1);
		wb(1'b1, 8'h40, 32'h0);
		rd(8'h40, 32'h1);
		wb(1'b1, 8'h40, 32'h1);
		wait_sig(0, 1'b0);
		rd(8'h40, 32'h0);
		pin_a_i[1] <= 1'b1;
		wait_sig(1, 1'b1);
		wb(1'b1, 8'h40, 32'h2);
		rd(8'h40, 32'h2);
		wb(1'b1, 8'h20, 32'h2);
		wait_sig(1, 1'b0);
		rd(8'h20, 32'hd);
		chk("events", 32'h0, {16'h0, event_cnt});
		wb(1'b1, 8'h10, 32'h2);
		nmi_pin_i <= 1'b0;
		wb(1'b1, 8'h08, 32'h4);
		nmi_pin_i <= 1'b1;
		wait_sig(NP, 1'b1);
		wait_sig(NP + 2, 1'b1);
		// Pin drops before the clear so the last synced high cannot set the flag again
		nmi_pin_i <= 1'b0;
		rd(8'h0c, 32'h1);
		wb(1'b1, 8'h0c, 32'h1);
		wait_sig(NP, 1'b0);
		wb(1'b1, 8'h30, 32'h2);
		chk("wake", 32'h0, {31'h0, wake_o});
		wb(1'b1, 8'h50, 32'h2);
		rd(8'h50, 32'h2);
		wait_sig(NP + 1, 1'b1);
		wb(1'b1, 8'h50, 32'h0);
		wait_sig(NP + 1, 1'b0);
		route_b_i[3] <= 1'b1;
		pin_b_i[3] <= 1'b1;
		repeat (8) @(posedge clk_i);
		rd(8'h40, 32'h2);
		route_a_i[3] <= 1'b0;
		wait_sig(3, 1'b1);
		pin_a_i[2] <= 1'b1;
		@(posedge clk_i);
		pin_a_i[2] <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("glitch", 32'h0, {31'h0, irq_o[2]});
		pin_a_i[2] <= 1'b1;
		wait_sig(2, 1'b1);
		for (int c = 0; c < 6; c++) begin
			wb(1'b1, 8'h60, 32'h0000_4b41 | (c << 16));
			wb(1'b1, 8'h40, 32'h10);
			repeat (8) @(posedge clk_i);
			rd(8'h40, (c == 5) ? 32'h1e : 32'h0e);
		end
		wb(1'b1, 8'h00, 32'h2);
		wb(1'b1, 8'h00, 32'h3);
		chk("stall", 32'h1, {31'h0, lat > 1});
		repeat (8) @(posedge clk_i);
		rd(8'h00, 32'h0);
		rd(8'h30, 32'h0);
		chk("irq", 32'h0, {14'h0, irq_o});
		end_sim();
	end
endmodule : tb
